// file: msc_consts.svh
/*
  Register indices, field positions, reset values and cycle counts of the
  flash CRC memory scanner. Assumes it is included by bare name.
*/
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

`define MSC_IDX_CONTROL_REG_FIRST 2'h0
`define MSC_IDX_CONTROL_REG_SECOND 2'h1
`define MSC_IDX_STATUS 2'h2

`define MSC_CONTROL_REG_FIRST_RESET_BIT 7
`define MSC_CONTROL_REG_FIRST_FAIL_INTERRUPT_ENABLE_BIT 1
`define MSC_CONTROL_REG_FIRST_EN_BIT 0
`define MSC_STATUS_OK_BIT 1
`define MSC_STATUS_BUSY_BIT 0

`define MSC_REGION_FLASH 2'h0
`define MSC_REGION_BOOTAPP 2'h1
`define MSC_REGION_BOOT 2'h2

`define MSC_CONTROL_REG_SECOND_RESET 2'h0
`define MSC_OK_RESET 1'h1
`define MSC_BUSY_RESET 1'h0

`define MSC_CRC_POLY 16'h1021
`define MSC_CRC_INIT 16'hFFFF
`define MSC_CRC_RESIDUE 16'h0000

`define MSC_START_DELAY 2'h3
`define MSC_FETCH_PERIOD 2'h3

`define MSC_RESP_OKAY 2'h0
`define MSC_RESP_SLVERR 2'h2

`endif

// file: msc_pkg.sv
/*
  Types shared by the flash CRC memory scanner: debugger write port,
  flash read request and answer, scan engine states.
  Assumes a 16-bit byte address space on the flash side.
*/
package msc_pkg;

  typedef struct packed
  {
    logic valid;
    logic [1:0] idx;
    logic [7:0] data;
  } msc_dbg_wr_t;

  typedef struct packed
  {
    logic req;
    logic [14:0] word_addr;
  } msc_flash_req_t;

  typedef struct packed
  {
    logic valid;
    logic [15:0] data;
  } msc_flash_rsp_t;

  typedef enum logic [1:0] {ENG_IDLE, ENG_DELAY, ENG_RUN, ENG_WAIT} msc_eng_t;

endpackage

// file: msc_scanner.sv
/*
  Flash CRC memory scanner: AXI4-Lite register slave, debugger port,
  CRC engine with priority flash read port and reset-time check.
  Assumes debugger, CPU, fuse and flash signals are on core_clk, the flash
  answers a request within two cycles and fuses are static.
  // How it works
  // R1 - crc-16 with polynomial x16+x12+x5+1 over the selected region
  // R2 - running checksum is preset to all ones before the first byte
  // R3 - bytes go in from address 0 upward, msb first
  // R4 - software stores checksum high byte second-to-last, low byte last
  // R5 - three regions, ends from fuse values times 256
  // R6 - match sets pass, mismatch shows fail and may raise nmi
  // R7 - nmi raised on failure and pass flag cleared then
  // R8 - debugger access suspends scanning, busy stays one
  // R9 - interrupted scan restarts from start on debug release
  // R10 - mirrored status readable by debugger, reading it releases scanner
  // R11 - debugger writing busy 0 aborts the check for good
  // R12 - debugger writing busy 1 runs one check after release
  // R13 - region select and nmi enable frozen while busy
  // R14 - debugger pass 0 raises nmi if enabled, then writes blocked
  // R15 - debugger pass 1 makes pass read one while idle
  // R16 - debugger control writes act like cpu writes
  // R17 - check starts three cycles after enable, cpu keeps running
  // R18 - failing reset-time scan keeps cpu held in reset
  // R19 - after reset-time scan enable reads 1, region shows checked one
  // R20 - priority flash access stalls cpu, one word every third cycle
  // R21 - scanning pauses while the cpu sleeps
  // R22 - region 0 whole flash, 1 boot plus code, 2 boot
  // R23 - pass is 1 at reset, cleared on enable, reads 0 while busy
  // R24 - nmi enable cleared only by system reset
  // R25 - region end addresses derived from static fuse inputs
  // R26 - flags update only after the last checksum byte is processed
*/
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "msc_consts.svh"

module msc_scanner #(
  parameter int ADDR_W = 12,
  parameter logic [15:0] FLASH_LAST = 16'hFFFF
) (
  input wire core_clk,
  input wire reset,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output logic s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire s_axi_rready,
  input msc_pkg::msc_dbg_wr_t dbg_wr,
  output logic dbg_wr_ready,
  input wire dbg_access,
  input wire dbg_internal_access,
  input wire dbg_disconnect,
  input wire dbg_status_read,
  output logic [1:0] dbg_status_mirror,
  output msc_pkg::msc_flash_req_t flash_rd,
  input msc_pkg::msc_flash_rsp_t flash_rsp,
  input wire cpu_sleep,
  output logic cpu_stall,
  output logic cpu_reset_hold,
  output logic nmi_req,
  input wire [7:0] boot_region_end_fuse,
  input wire [7:0] code_region_end_fuse,
  input wire [1:0] reset_scan_region_fuse,
  input wire reset_scan_enable_fuse
);
  import msc_pkg::*;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[15] ^ d[i])
        r = {r[14:0], 1'b0} ^ `MSC_CRC_POLY; // [R1] [R3]
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // last byte address of a region; reserved code falls back to whole flash
  function automatic logic [15:0] region_last(input logic [1:0] sel);
    logic [15:0] r;
    r = FLASH_LAST; // [R22]
    if (sel == `MSC_REGION_BOOTAPP)
      r = {code_region_end_fuse, 8'h00} - 16'h0001; // [R5] [R25]
    else if (sel == `MSC_REGION_BOOT)
      r = {boot_region_end_fuse, 8'h00} - 16'h0001; // [R5] [R25]
    return r;
  endfunction

  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic enable_q;
  logic fail_interrupt_enable_q;
  logic [1:0] region_select_q;
  logic busy_q;
  logic pass_q;
  logic nmi_q;
  logic srst_q;
  logic susp_q;
  logic init_arm_q;
  logic init_q;
  logic [1:0] mirror_q;

  msc_eng_t eng_q;
  logic [15:0] crc_q;
  logic [14:0] word_q;
  logic [1:0] dly_q;
  logic [1:0] gap_q;

  logic commit;
  logic aw_mapped;
  logic wr_go;
  logic wr_dbg;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_control_reg_first;
  logic wr_control_reg_second;
  logic wr_stat;
  logic start_sw;
  logic dbg_busy0;
  logic dbg_busy1;
  logic dbg_pass0;
  logic dbg_pass1;
  logic release_evt;
  logic resume;
  logic init_start;
  logic go;
  logic take_rsp;
  logic [15:0] crc_nx;
  logic last_word;
  logic [15:0] last_byte;
  logic scan_done;
  logic scan_fail;
  logic pass_rd;

  // write address and data are latched separately, in either order
  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ~w_full_q & ~bvalid_q;
  assign commit = aw_full_q & w_full_q;
  assign aw_mapped = (aw_addr_q[ADDR_W-1:4] == '0) && (aw_addr_q[3:2] <= `MSC_IDX_STATUS);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (commit)
      aw_full_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_strb_q <= s_axi_wstrb[0];
    end
    else if (commit)
      w_full_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `MSC_RESP_OKAY;
    end
    else if (commit)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= aw_mapped ? `MSC_RESP_OKAY : `MSC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // status is read-only from the cpu; only the debugger port writes it
  assign dbg_wr_ready = ~commit;
  assign wr_dbg = dbg_wr.valid & ~commit;
  assign wr_go = (commit & aw_mapped & w_strb_q & (aw_addr_q[3:2] != `MSC_IDX_STATUS)) | wr_dbg; // [R16]
  assign wr_idx = commit ? aw_addr_q[3:2] : dbg_wr.idx;
  assign wr_data = commit ? w_data_q : dbg_wr.data;

  // once the nmi has fired every register write is dropped
  assign wr_control_reg_first = wr_go & ~nmi_q & (wr_idx == `MSC_IDX_CONTROL_REG_FIRST); // [R14]
  assign wr_control_reg_second = wr_go & ~nmi_q & (wr_idx == `MSC_IDX_CONTROL_REG_SECOND); // [R14]
  assign wr_stat = wr_dbg & ~nmi_q & (wr_idx == `MSC_IDX_STATUS); // [R14]

  assign start_sw = wr_control_reg_first & wr_data[`MSC_CONTROL_REG_FIRST_EN_BIT] & ~busy_q;
  assign dbg_busy0 = wr_stat & ~wr_data[`MSC_STATUS_BUSY_BIT]; // [R11]
  assign dbg_busy1 = wr_stat & wr_data[`MSC_STATUS_BUSY_BIT]; // [R12]
  assign dbg_pass0 = wr_stat & ~wr_data[`MSC_STATUS_OK_BIT];
  assign dbg_pass1 = wr_stat & wr_data[`MSC_STATUS_OK_BIT];

  assign pass_rd = pass_q & ~busy_q; // [R23]

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `MSC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= `MSC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      if (s_axi_araddr[ADDR_W-1:4] != '0)
        rresp_q <= `MSC_RESP_SLVERR;
      else
      begin
        unique case (s_axi_araddr[3:2])
          `MSC_IDX_CONTROL_REG_FIRST: rdata_q[1:0] <= {fail_interrupt_enable_q, enable_q};
          `MSC_IDX_CONTROL_REG_SECOND: rdata_q[1:0] <= region_select_q;
          `MSC_IDX_STATUS: rdata_q[1:0] <= {pass_rd, busy_q};
          default: rresp_q <= `MSC_RESP_SLVERR;
        endcase
      end
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // soft reset lands one cycle after the write; blocked while busy with nmi enabled
  always_ff @(posedge core_clk)
  begin
    if (reset)
      srst_q <= 1'b0;
    else
      srst_q <= wr_control_reg_first & wr_data[`MSC_CONTROL_REG_FIRST_RESET_BIT] & (~fail_interrupt_enable_q | ~busy_q);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      enable_q <= 1'b0;
    else if (srst_q)
      enable_q <= 1'b0;
    else if (init_start)
      enable_q <= 1'b1; // [R19]
    else if (wr_control_reg_first)
      enable_q <= wr_data[`MSC_CONTROL_REG_FIRST_EN_BIT];
  end

  // only a system reset clears it; the soft reset leaves it alone
  always_ff @(posedge core_clk)
  begin
    if (reset)
      fail_interrupt_enable_q <= 1'b0; // [R24]
    else if (wr_control_reg_first && !busy_q && wr_data[`MSC_CONTROL_REG_FIRST_FAIL_INTERRUPT_ENABLE_BIT])
      fail_interrupt_enable_q <= 1'b1; // [R13]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      region_select_q <= `MSC_CONTROL_REG_SECOND_RESET;
    else if (srst_q)
      region_select_q <= `MSC_CONTROL_REG_SECOND_RESET;
    else if (init_start)
      region_select_q <= reset_scan_region_fuse; // [R19]
    else if (wr_control_reg_second && !busy_q)
      region_select_q <= wr_data[1:0]; // [R13] [R22]
  end

  // fuses are sampled the cycle after reset release, never under reset
  assign init_start = init_arm_q & reset_scan_enable_fuse;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      init_arm_q <= 1'b1;
      init_q <= 1'b0;
    end
    else
    begin
      init_arm_q <= 1'b0;
      if (init_start)
        init_q <= 1'b1;
      else if (scan_done && !scan_fail)
        init_q <= 1'b0;
    end
  end

  // a failed reset-time check holds the cpu until a later check passes
  assign cpu_reset_hold = init_arm_q | init_q; // [R18]

  // debugger access wins over a release arriving in the same cycle
  assign release_evt = dbg_internal_access | dbg_disconnect | dbg_status_read; // [R9] [R10]
  assign resume = susp_q & release_evt & ~dbg_access;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      susp_q <= 1'b0;
    else if (dbg_access)
      susp_q <= 1'b1; // [R8]
    else if (release_evt)
      susp_q <= 1'b0; // [R9] [R10]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      busy_q <= `MSC_BUSY_RESET;
    else if (srst_q || dbg_busy0)
      busy_q <= 1'b0; // [R11]
    else if (start_sw || dbg_busy1 || init_start)
      busy_q <= 1'b1; // [R12]
    else if (scan_done)
      busy_q <= 1'b0; // [R26]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      pass_q <= `MSC_OK_RESET; // [R23]
    else if (srst_q)
      pass_q <= `MSC_OK_RESET;
    else if (scan_done)
      pass_q <= ~scan_fail; // [R6] [R7] [R26]
    else if (start_sw || init_start || dbg_pass0)
      pass_q <= 1'b0; // [R23]
    else if (dbg_pass1)
      pass_q <= 1'b1; // [R15]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      nmi_q <= 1'b0;
    else if (fail_interrupt_enable_q && (scan_fail || dbg_pass0))
      nmi_q <= 1'b1; // [R6] [R7] [R14]
  end

  assign nmi_req = nmi_q;

  // copies for the debugger's own space; reading them does not suspend
  always_ff @(posedge core_clk)
  begin
    if (reset)
      mirror_q <= {`MSC_OK_RESET, `MSC_BUSY_RESET};
    else
      mirror_q <= {pass_rd, busy_q}; // [R10]
  end

  assign dbg_status_mirror = mirror_q;

  // scanning only moves while busy, not suspended and the cpu is awake
  assign go = busy_q & ~susp_q & ~cpu_sleep & ~init_arm_q; // [R8] [R21]
  // a word already in flight is kept through sleep; dropping it would leave the engine waiting forever
  assign take_rsp = (eng_q == ENG_WAIT) & flash_rsp.valid & busy_q & ~susp_q; // [R21]
  assign crc_nx = crc_byte(crc_byte(crc_q, flash_rsp.data[7:0]), flash_rsp.data[15:8]); // [R3]
  assign last_byte = region_last(region_select_q);
  assign last_word = (word_q == last_byte[15:1]);
  // appended big-endian checksum drives a matching crc to zero
  assign scan_done = take_rsp & last_word; // [R4] [R26]
  assign scan_fail = scan_done & (crc_nx != `MSC_CRC_RESIDUE); // [R6]

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      eng_q <= ENG_IDLE;
      crc_q <= `MSC_CRC_INIT;
      word_q <= '0;
      dly_q <= 2'h0;
    end
    else if (srst_q || dbg_busy0)
      eng_q <= ENG_IDLE; // [R11]
    else if (start_sw || dbg_busy1 || init_start || (resume && busy_q))
    begin
      crc_q <= `MSC_CRC_INIT; // [R2]
      word_q <= '0; // [R3] [R9]
      dly_q <= `MSC_START_DELAY; // [R17]
      eng_q <= start_sw ? ENG_DELAY : ENG_RUN;
    end
    else
    begin
      unique case (eng_q)
        ENG_IDLE: ;
        ENG_DELAY:
        begin
          if (!cpu_sleep)
          begin
            dly_q <= dly_q - 2'h1;
            if (dly_q == 2'h1)
              eng_q <= ENG_RUN; // [R17]
          end
        end
        ENG_RUN:
        begin
          if (go && gap_q == 2'h0)
            eng_q <= ENG_WAIT;
        end
        ENG_WAIT:
        begin
          if (take_rsp)
          begin
            crc_q <= crc_nx; // [R1]
            word_q <= word_q + 15'h0001;
            eng_q <= last_word ? ENG_IDLE : ENG_RUN;
          end
        end
      endcase
    end
  end

  // spacing between fetches; reaches zero three cycles after a request
  always_ff @(posedge core_clk)
  begin
    if (reset)
      gap_q <= 2'h0;
    else if (flash_rd.req)
      gap_q <= `MSC_FETCH_PERIOD - 2'h1; // [R20]
    else if (go && gap_q != 2'h0)
      gap_q <= gap_q - 2'h1;
  end

  always_comb
  begin
    flash_rd.req = (eng_q == ENG_RUN) & go & (gap_q == 2'h0); // [R20]
    flash_rd.word_addr = word_q;
  end

  // cpu waits while the scanner owns the flash; the start delay is not stalled
  assign cpu_stall = go & ((eng_q == ENG_RUN) | (eng_q == ENG_WAIT)); // [R17] [R20]

endmodule

// file: msc_scanner_props.sv
/*
  Port checker for the flash CRC memory scanner.
  Assumes one clock domain; bound to the scanner from the bench.
*/
`timescale 1ns/1ps
module msc_scanner_props #(
  parameter int ADDR_W = 12
) (
  input wire core_clk,
  input wire reset,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input msc_pkg::msc_dbg_wr_t dbg_wr,
  input wire dbg_wr_ready,
  input wire dbg_access,
  input wire [1:0] dbg_status_mirror,
  input msc_pkg::msc_flash_req_t flash_rd,
  input wire cpu_sleep,
  input wire cpu_stall,
  input wire cpu_reset_hold,
  input wire nmi_req
);
  import msc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // only an idle, healthy, awake scanner starts on the enable write
  sequence en_write;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == '0 && s_axi_wstrb[0]
      && s_axi_wdata[0] && !nmi_req && dbg_status_mirror == 2'b10 && !cpu_sleep;
  endsequence
  sequence stat_wr;
    dbg_wr.valid && dbg_wr.idx == 2'h2 && dbg_wr_ready && !nmi_req && !dbg_access;
  endsequence
  a_start_delay: assert property (en_write |=> !flash_rd.req [*4] ##1 flash_rd.req)
    else $error("scan start delay wrong");
  a_req_gap: assert property (flash_rd.req |=> !flash_rd.req [*2])
    else $error("flash fetch gap too short");
  a_stall_own: assert property (flash_rd.req |-> cpu_stall)
    else $error("fetch without cpu stall");
  a_sleep_halt: assert property (cpu_sleep |-> !flash_rd.req)
    else $error("fetch while cpu sleeps");
  a_dbg_halt: assert property (dbg_access |=> !flash_rd.req)
    else $error("fetch after debugger access");
  a_busy_read: assert property (flash_rd.req |=> ##1 dbg_status_mirror == 2'b01)
    else $error("status not busy during fetch");
  a_nmi_sticky: assert property (nmi_req |=> nmi_req)
    else $error("nmi request dropped");
  a_nmi_fail: assert property ($rose(nmi_req) |=> !dbg_status_mirror[1])
    else $error("pass flag set with nmi");
  a_dbg_abort: assert property (stat_wr ##0 !dbg_wr.data[0] |=> !flash_rd.req [*8])
    else $error("scan went on after abort");
  a_pass_set: assert property (stat_wr ##0 dbg_wr.data[1:0] == 2'b10 |=> ##1 dbg_status_mirror == 2'b10)
    else $error("pass not set by debugger");
  a_hold_fail: assert property ($fell(dbg_status_mirror[0]) && !dbg_status_mirror[1] && cpu_reset_hold
    |=> cpu_reset_hold [*8])
    else $error("cpu released after failed scan");
endmodule

// file: msc_flash_model.sv
/*
  Behavioural program flash answering scanner word fetches.
  Assumes the bench loads mem; slow adds one cycle of latency.
*/
`timescale 1ns/1ps
module msc_flash_model (
  input wire core_clk,
  input wire slow,
  input msc_pkg::msc_flash_req_t flash_rd,
  output msc_pkg::msc_flash_rsp_t flash_rsp
);
  import msc_pkg::*;
  logic [7:0] mem [0:767];
  logic v1 = 1'b0;
  logic [15:0] d1 = '0;
  logic [15:0] w;
  initial flash_rsp = '0;
  // even byte in the low half
  assign w = {mem[{flash_rd.word_addr, 1'b1}], mem[{flash_rd.word_addr, 1'b0}]};
  always @(posedge core_clk)
  begin
    v1 <= flash_rd.req;
    d1 <= w;
    flash_rsp.valid <= slow ? v1 : flash_rd.req;
    // idle data toggles so a stale word is never mistaken for an answer
    if (slow ? v1 : flash_rd.req)
      flash_rsp.data <= slow ? d1 : w;
    else
      flash_rsp.data <= ~flash_rsp.data;
  end
endmodule

// file: tb_top.sv
/*
  Bench for the flash CRC memory scanner: AXI4-Lite and debugger tasks.
  Assumes the flash model and the port checker bound below.
*/
`timescale 1ns/1ps
module tb_top;
  import msc_pkg::*;
  logic core_clk = 0, reset = 1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  // answer readies stay high, so back-to-back calls never drive them twice in one step
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic dbg_wr_ready, cpu_stall, cpu_reset_hold, nmi_req;
  logic [1:0] s_axi_bresp, s_axi_rresp, dbg_status_mirror, reset_scan_region_fuse = 2'h1;
  logic dbg_access = 0, dbg_internal_access = 0, dbg_disconnect = 0, dbg_status_read = 0;
  logic cpu_sleep = 0, slow = 0, reset_scan_enable_fuse = 0;
  logic [7:0] boot_region_end_fuse = 8'h01, code_region_end_fuse = 8'h02;
  msc_dbg_wr_t dbg_wr = '0;
  msc_flash_req_t flash_rd;
  msc_flash_rsp_t flash_rsp;
  int mismatches = 0, checked = 0, i;

  msc_scanner #(.FLASH_LAST(16'h02FF)) i_dut (.*);
  msc_flash_model i_flash (.*);

  initial forever #4 core_clk = ~core_clk;

  task report_and_stop;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial
  begin
    #400000;
    mismatches++;
    report_and_stop;
  end

  task chk(input logic [33:0] g, input logic [33:0] e);
    begin
      checked++;
      if (g !== e)
      begin
        mismatches++;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  function automatic logic [15:0] crc(input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int k = 0; k < n; k++)
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ i_flash.mem[k][b]) ? 16'h1021 : 16'h0);
    return c;
  endfunction

  task put(input int l);
    logic [15:0] c;
    begin
      c = crc(l - 1);
      i_flash.mem[l - 1] = c[15:8];
      i_flash.mem[l] = c[7:0];
    end
  endtask

  // handshakes are judged at the falling edge, where they equal what the next rising edge samples
  task wr(input int a, input int d);
    logic ah, wh, bh;
    begin
      s_axi_awaddr <= a[11:0];
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      bh = 0;
      while (!bh)
      begin
        @(negedge core_clk);
        ah = s_axi_awvalid & s_axi_awready;
        wh = s_axi_wvalid & s_axi_wready;
        bh = s_axi_bvalid;
        @(posedge core_clk);
        if (ah)
          s_axi_awvalid <= 1'b0;
        if (wh)
          s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task rd(input int a, input int e, input logic [1:0] r = 2'h0);
    logic ah, h;
    logic [33:0] v;
    begin
      s_axi_araddr <= a[11:0];
      s_axi_arvalid <= 1'b1;
      h = 0;
      while (!h)
      begin
        @(negedge core_clk);
        ah = s_axi_arvalid & s_axi_arready;
        h = s_axi_rvalid;
        v = {s_axi_rresp, s_axi_rdata};
        @(posedge core_clk);
        if (ah)
          s_axi_arvalid <= 1'b0;
      end
      chk(v, {r, e[31:0]});
    end
  endtask

  task dw(input int x, input int d);
    begin
      dbg_wr <= {1'b1, x[1:0], d[7:0]};
      @(posedge core_clk);
      dbg_wr <= '0;
      @(posedge core_clk);
    end
  endtask

  task idle;
    int n;
    begin
      n = 0;
      repeat (4) @(posedge core_clk);
      while (dbg_status_mirror[0] !== 1'b0 && n < 5000)
      begin
        @(negedge core_clk);
        n++;
      end
      // a scan that never finishes is a failure, not a silent pass-through
      if (n >= 5000)
        mismatches++;
      @(posedge core_clk);
    end
  endtask

  task rst;
    begin
      reset <= 1;
      repeat (16) @(posedge core_clk);
      reset <= 0;
      @(posedge core_clk);
    end
  endtask

  // let the start delay run out before anything else touches the scan
  task go;
    begin
      wr(0, 1);
      repeat (9) @(posedge core_clk);
    end
  endtask

  task susp(input int k);
    begin
      dbg_access <= 1;
      @(posedge core_clk);
      dbg_access <= 0;
      repeat (20) @(posedge core_clk);
      chk(dbg_status_mirror, 1);
      dbg_internal_access <= (k == 0);
      dbg_disconnect <= (k == 1);
      dbg_status_read <= (k == 2);
      @(posedge core_clk);
      {dbg_internal_access, dbg_disconnect, dbg_status_read} <= '0;
      idle;
    end
  endtask

  initial
  begin
    for (i = 0; i < 768; i++)
      i_flash.mem[i] = i[7:0] ^ 8'h5A;
    put(255);
    put(511);
    put(767);
    rst;
    rd(0, 0);
    rd(8, 2);
    rd(12'hC, 0, 2'h2);
    for (i = 2; i >= 0; i--)
    begin
      slow <= (i == 1);
      wr(4, i);
      rd(4, i);
      go;
      rd(8, 1);
      idle;
      rd(8, 2);
    end
    go;
    wr(4, 2);
    wr(0, 3);
    rd(4, 0);
    rd(0, 1);
    susp(0);
    rd(8, 2);
    go;
    dw(2, 0);
    rd(8, 0);
    dw(2, 2);
    rd(8, 2);
    dw(1, 1);
    rd(4, 1);
    dw(2, 1);
    susp(1);
    rd(8, 2);
    go;
    cpu_sleep <= 1;
    repeat (30) @(posedge core_clk);
    chk(dbg_status_mirror, 1);
    cpu_sleep <= 0;
    idle;
    rd(8, 2);
    go;
    susp(2);
    rd(8, 2);
    wr(0, 2);
    wr(0, 8'h80);
    rd(0, 2);
    i_flash.mem[5] ^= 8'h01;
    wr(4, 2);
    go;
    idle;
    rd(8, 0);
    chk(nmi_req, 1);
    wr(4, 1);
    rd(4, 2);
    i_flash.mem[5] ^= 8'h01;
    reset_scan_enable_fuse <= 1;
    rst;
    idle;
    rd(0, 1);
    rd(4, 1);
    chk(cpu_reset_hold, 0);
    i_flash.mem[5] ^= 8'h01;
    rst;
    idle;
    chk(cpu_reset_hold, 1);
    reset_scan_enable_fuse <= 0;
    rst;
    wr(0, 2);
    dw(2, 0);
    chk(nmi_req, 1);
    dw(2, 2);
    rd(8, 0);
    report_and_stop;
  end
endmodule

bind msc_scanner msc_scanner_props #(.ADDR_W(ADDR_W)) i_props (.*);
